// *** src/phs_pkg.sv ***
// Purpose: Shared constants for the performance state hint register bank.
// Assumes: Registers are reached by a 12-bit register index with 64-bit data.
// Notes:   Timing counts derive from the 25 MHz system clock.
package phs_pkg;

	localparam int          ADDR_W          = 12;
	localparam int          DATA_W          = 64;
	localparam int          LVL_W           = 8;

	// Register indices
	localparam logic [11:0] OFS_THERM       = 12'h19C;
	localparam logic [11:0] OFS_LEGACY_CTL  = 12'h199;
	localparam logic [11:0] OFS_PROD_COUNT  = 12'h64E;
	localparam logic [11:0] OFS_ENABLE      = 12'h770;
	localparam logic [11:0] OFS_CAPABILITY  = 12'h771;
	localparam logic [11:0] OFS_PKG_REQ     = 12'h772;
	localparam logic [11:0] OFS_INT_CTL     = 12'h773;
	localparam logic [11:0] OFS_PROC_REQ    = 12'h774;
	localparam logic [11:0] OFS_STATUS      = 12'h777;

	// Identification flag positions
	localparam int          ID_BASELINE     = 7;
	localparam int          ID_NOTIFY       = 8;
	localparam int          ID_WINDOW       = 9;
	localparam int          ID_PREFERENCE   = 10;
	localparam int          ID_PKG_REQ      = 11;

	// Enable register
	localparam int          EN_BIT          = 0;

	// Capability fields (low bit of each byte field)
	localparam int          CAP_HIGHEST_LSB = 0;
	localparam int          CAP_GUAR_LSB    = 8;
	localparam int          CAP_EFFIC_LSB   = 16;
	localparam int          CAP_LOWEST_LSB  = 24;

	// Request fields
	localparam int          REQ_MIN_LSB     = 0;
	localparam int          REQ_MAX_LSB     = 8;
	localparam int          REQ_DES_LSB     = 16;
	localparam int          REQ_PREF_LSB    = 24;
	localparam int          REQ_WIN_LSB     = 32;
	localparam int          REQ_WIN_W       = 10;
	localparam int          REQ_PKG_BIT     = 42;
	localparam logic [7:0]  REQ_PREF_RST    = 8'h80;
	localparam logic [7:0]  REQ_DES_RST     = 8'h00;

	// Status and interrupt control bits
	localparam int          ST_GUAR_BIT     = 0;
	localparam int          ST_EXCUR_BIT    = 2;
	localparam int          IC_GUAR_BIT     = 0;
	localparam int          IC_EXCUR_BIT    = 1;

	// Thermal status excursion reason bits
	localparam int          TH_CUR_STAT     = 12;
	localparam int          TH_CUR_LOG      = 13;
	localparam int          TH_XDOM_STAT    = 14;
	localparam int          TH_XDOM_LOG     = 15;

	// Timing
	localparam longint      CLK_HZ          = 25000000;
	localparam longint      SETTLE_TIME_MS  = 1000;
	// Strictly more than the settle time
	localparam longint      SETTLE_CYC      = (SETTLE_TIME_MS * CLK_HZ) / 1000 + 1;

endpackage

// *** src/phs_regs.sv ***
// Purpose: Register bank for hardware-managed performance state hints.
// Assumes: One request per cycle on MSR_RD or MSR_WR, answered next cycle.
// Notes:   Level inputs from the power controller are asynchronous.
// Summary of operation
// - Identification bit 7 reports enable, capability, request and status registers.
// - Identification bit 8 reports the interrupt control register.
// - Identification bit 9 reports a writable activity window field.
// - Identification bit 10 reports a writable preference hint field.
// - Identification bit 11 reports the package-wide request register.
// - Enable bit 0 switches to autonomous performance selection.
// - While enabled, writes to the legacy control register are ignored.
// - Enable bit sets once; later writes to it are ignored.
// - Enable bit resets to 0; only reset clears it.
// - Capability, request, status need enable first; interrupt control and counter exempt.
// - Interrupt control is reachable whenever present, enabled or not.
// - Enable register is package wide, one bit for all processors.
// - Capability bits 7:0 highest level, bits 15:8 current guaranteed level.
// - Capability bits 23:16 most efficient level, bits 31:24 lowest level.
// - Capability bits 63:32 read zero.
// - Guaranteed level change sets status and, if enabled, the interrupt.
// - A guaranteed change counts only after holding more than one second.
// - Requested maximum below most efficient level may be disregarded.
// - Status shows guaranteed changes and excursions to minimum.
// - Thermal status bits 15:12 carry excursion reasons.
module phs_regs
	import phs_pkg::*;
#(
	parameter bit          HAS_BASELINE  = 1'b1,
	parameter bit          HAS_NOTIFY    = 1'b1,
	parameter bit          HAS_WINDOW    = 1'b1,
	parameter bit          HAS_PREF      = 1'b1,
	parameter bit          HAS_PKG       = 1'b1,
	parameter bit          HAS_PROD_CNT  = 1'b1,
	parameter logic [7:0]  HIGHEST_PERF  = 8'hFF,
	parameter logic [7:0]  LOWEST_PERF   = 8'h01,
	parameter int unsigned SETTLE_CYCLES = 32'(SETTLE_CYC)
) (
	input  wire logic        CLK,              // System clock, 25 MHz
	input  wire logic        RST,              // Synchronous reset, high
	input  wire logic        MSR_RD,           // Read request pulse
	input  wire logic        MSR_WR,           // Write request pulse
	input  wire logic [11:0] MSR_ADDR,         // Register index
	input  wire logic [63:0] MSR_WDATA,        // Write data
	output logic      [63:0] MSR_RDATA,        // Read data
	output logic             MSR_ACK,          // Answer pulse
	output logic             MSR_FAULT,        // Access refused, with ACK
	output logic      [31:0] FEATURE_FLAGS,    // Identification word
	input  wire logic [7:0]  GUAR_PERF_IN,     // Guaranteed level, async
	input  wire logic [7:0]  EFFIC_PERF_IN,    // Most efficient level, async
	input  wire logic        MIN_EXCURSION_IN, // Running at minimum, async
	input  wire logic        CURRENT_LIMIT_IN, // Current limit active, async
	input  wire logic        CROSS_DOMAIN_IN,  // Other domain limiting, async
	input  wire logic        PRODUCTIVE_IN,    // Productive cycle, async
	output logic             AUTO_SEL_EN,      // Autonomous selection on
	output logic      [63:0] LEGACY_PERF_CTL,  // Legacy control value
	output logic      [7:0]  PERF_MIN_OUT,     // Effective minimum hint
	output logic      [7:0]  PERF_MAX_OUT,     // Effective maximum hint
	output logic      [7:0]  PERF_DESIRED_OUT, // Effective desired hint
	output logic      [7:0]  PERF_PREF_OUT,    // Effective preference hint
	output logic      [9:0]  PERF_WINDOW_OUT,  // Effective activity window
	output logic             PERF_NOTIFY_IRQ   // Notification interrupt
);

	localparam int SYNC_W = 2 * LVL_W + 4;

	initial begin
		if (LOWEST_PERF > HIGHEST_PERF) $error("phs_regs: lowest above highest");
		if (SETTLE_CYCLES < 1) $error("phs_regs: SETTLE_CYCLES below 1");
	end

	logic [SYNC_W-1:0] sync_q;
	logic [7:0]        guar_raw;
	logic [7:0]        effic_s;
	logic              excur_s;
	logic              cur_lim_s;
	logic              xdom_s;
	logic              prod_s;
	logic [7:0]        guar_lvl;
	logic              guar_chg;
	logic              excur_d_ff;

	logic              enable_ff;
	logic [63:0]       legacy_ff;
	logic [63:0]       proc_req_ff;
	logic [63:0]       pkg_req_ff;
	logic [63:0]       int_ctl_ff;
	logic [63:0]       status_ff;
	logic              cur_log_ff;
	logic              xdom_log_ff;
	logic [63:0]       prod_cnt_ff;
	logic [63:0]       rd_val;
	logic              acc_ok;

	phs_sync #(
		.W (SYNC_W)
	) u_sync (
		.clk (CLK),
		.rst (RST),
		.d   ({GUAR_PERF_IN, EFFIC_PERF_IN, MIN_EXCURSION_IN,
		       CURRENT_LIMIT_IN, CROSS_DOMAIN_IN, PRODUCTIVE_IN}),
		.q   (sync_q)
	);

	assign {guar_raw, effic_s, excur_s, cur_lim_s, xdom_s, prod_s} = sync_q;

	// Filter waits for live synchroniser output, else cleared stages look like a change
	logic [1:0] warm_ff;
	logic       settle_rst;

	always_ff @(posedge CLK) begin
		if (RST) begin
			warm_ff <= 2'b00;
		end else begin
			warm_ff <= {warm_ff[0], 1'b1};
		end
	end

	assign settle_rst = RST || !warm_ff[1];

	phs_settle #(
		.W      (LVL_W),
		.CYCLES (SETTLE_CYCLES)
	) u_settle (
		.clk      (CLK),
		.rst      (settle_rst),
		.level_in (guar_raw),
		.level    (guar_lvl),
		.changed  (guar_chg)
	);

	// Which register indices answer, given features and enable state
	function automatic logic access_ok(input logic [11:0] a, input logic en);
		unique case (a)
			OFS_ENABLE:     access_ok = HAS_BASELINE;
			OFS_CAPABILITY,
			OFS_PROC_REQ,
			OFS_STATUS:     access_ok = HAS_BASELINE && en;
			OFS_PKG_REQ:    access_ok = HAS_BASELINE && HAS_PKG && en;
			OFS_INT_CTL:    access_ok = HAS_BASELINE && HAS_NOTIFY;
			OFS_PROD_COUNT: access_ok = HAS_PROD_CNT;
			OFS_THERM,
			OFS_LEGACY_CTL: access_ok = 1'b1;
			default:        access_ok = 1'b0;
		endcase
	endfunction

	// Writable bits of a request register; unsupported fields stay zero
	function automatic logic [63:0] req_mask(input logic is_pkg);
		logic [63:0] m;
		m = 64'h0000_0000_00FF_FFFF;
		if (HAS_PREF) m[REQ_PREF_LSB +: 8] = 8'hFF;
		if (HAS_WINDOW) m[REQ_WIN_LSB +: REQ_WIN_W] = '1;
		if (HAS_PKG && !is_pkg) m[REQ_PKG_BIT] = 1'b1;
		req_mask = m;
	endfunction

	function automatic logic [63:0] req_reset();
		logic [63:0] v;
		v = 64'h0;
		v[REQ_MIN_LSB +: 8] = LOWEST_PERF;
		v[REQ_MAX_LSB +: 8] = HIGHEST_PERF;
		v[REQ_DES_LSB +: 8] = REQ_DES_RST;
		v[REQ_PREF_LSB +: 8] = HAS_PREF ? REQ_PREF_RST : 8'h00;
		req_reset = v;
	endfunction

	assign acc_ok = access_ok(MSR_ADDR, enable_ff);

	logic wr_ok;
	assign wr_ok = MSR_WR && acc_ok;

	// Identification word
	always_ff @(posedge CLK) begin
		if (RST) begin
			FEATURE_FLAGS <= 32'h0000_0000;
		end else begin
			FEATURE_FLAGS                <= 32'h0000_0000;
			FEATURE_FLAGS[ID_BASELINE]   <= HAS_BASELINE;
			FEATURE_FLAGS[ID_NOTIFY]     <= HAS_BASELINE && HAS_NOTIFY;
			FEATURE_FLAGS[ID_WINDOW]     <= HAS_BASELINE && HAS_WINDOW;
			FEATURE_FLAGS[ID_PREFERENCE] <= HAS_BASELINE && HAS_PREF;
			FEATURE_FLAGS[ID_PKG_REQ]    <= HAS_BASELINE && HAS_PKG;
		end
	end

	// Package-wide enable, set once, cleared by reset only
	always_ff @(posedge CLK) begin
		if (RST) begin
			enable_ff <= 1'b0;
		end else if (wr_ok && MSR_ADDR == OFS_ENABLE && !enable_ff) begin
			// Reserved bits are dropped; a zero write leaves it clear
			enable_ff <= MSR_WDATA[EN_BIT];
		end
	end

	// Legacy control freezes once autonomous selection owns the levels
	always_ff @(posedge CLK) begin
		if (RST) begin
			legacy_ff <= 64'h0;
		end else if (wr_ok && MSR_ADDR == OFS_LEGACY_CTL && !enable_ff) begin
			legacy_ff <= MSR_WDATA;
		end
	end

	// Request registers; reads return the last value written, with bits outside req_mask cleared
	always_ff @(posedge CLK) begin
		if (RST) begin
			proc_req_ff <= req_reset();
			pkg_req_ff  <= HAS_PKG ? req_reset() : 64'h0;
		end else if (wr_ok) begin
			if (MSR_ADDR == OFS_PROC_REQ) proc_req_ff <= MSR_WDATA & req_mask(1'b0);
			if (MSR_ADDR == OFS_PKG_REQ) pkg_req_ff <= MSR_WDATA & req_mask(1'b1);
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			int_ctl_ff <= 64'h0;
		end else if (wr_ok && MSR_ADDR == OFS_INT_CTL) begin
			int_ctl_ff <= 64'h0;
			int_ctl_ff[IC_GUAR_BIT]  <= MSR_WDATA[IC_GUAR_BIT];
			int_ctl_ff[IC_EXCUR_BIT] <= MSR_WDATA[IC_EXCUR_BIT];
		end
	end

	// Status: hardware set beats a same-cycle clear by software
	always_ff @(posedge CLK) begin
		if (RST) begin
			status_ff  <= 64'h0;
			excur_d_ff <= 1'b0;
		end else begin
			excur_d_ff <= excur_s;
			if (wr_ok && MSR_ADDR == OFS_STATUS) begin
				if (!MSR_WDATA[ST_GUAR_BIT]) status_ff[ST_GUAR_BIT] <= 1'b0;
				if (!MSR_WDATA[ST_EXCUR_BIT]) status_ff[ST_EXCUR_BIT] <= 1'b0;
			end
			if (guar_chg) status_ff[ST_GUAR_BIT] <= 1'b1;
			if (enable_ff && excur_s && !excur_d_ff) begin
				status_ff[ST_EXCUR_BIT] <= 1'b1;
			end
		end
	end

	// Sticky reason logs beside the live reason levels
	always_ff @(posedge CLK) begin
		if (RST) begin
			cur_log_ff  <= 1'b0;
			xdom_log_ff <= 1'b0;
		end else begin
			if (wr_ok && MSR_ADDR == OFS_THERM) begin
				if (!MSR_WDATA[TH_CUR_LOG]) cur_log_ff <= 1'b0;
				if (!MSR_WDATA[TH_XDOM_LOG]) xdom_log_ff <= 1'b0;
			end
			if (cur_lim_s) cur_log_ff <= 1'b1;
			if (xdom_s) xdom_log_ff <= 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			prod_cnt_ff <= 64'h0;
		end else if (HAS_PROD_CNT && prod_s) begin
			prod_cnt_ff <= prod_cnt_ff + 64'h1;
		end
	end

	// Read data selection
	always_comb begin
		rd_val = 64'h0;
		unique case (MSR_ADDR)
			OFS_ENABLE:     rd_val[EN_BIT] = enable_ff;
			OFS_CAPABILITY: begin
				rd_val[CAP_HIGHEST_LSB +: 8] = HIGHEST_PERF;
				rd_val[CAP_GUAR_LSB +: 8]    = guar_lvl;
				rd_val[CAP_EFFIC_LSB +: 8]   = effic_s;
				rd_val[CAP_LOWEST_LSB +: 8]  = LOWEST_PERF;
			end
			OFS_PROC_REQ:   rd_val = proc_req_ff;
			OFS_PKG_REQ:    rd_val = pkg_req_ff;
			OFS_INT_CTL:    rd_val = int_ctl_ff;
			OFS_STATUS:     rd_val = status_ff;
			OFS_PROD_COUNT: rd_val = prod_cnt_ff;
			OFS_LEGACY_CTL: rd_val = legacy_ff;
			OFS_THERM: begin
				rd_val[TH_CUR_STAT]  = cur_lim_s;
				rd_val[TH_CUR_LOG]   = cur_log_ff;
				rd_val[TH_XDOM_STAT] = xdom_s;
				rd_val[TH_XDOM_LOG]  = xdom_log_ff;
			end
			default:        rd_val = 64'h0;
		endcase
	end

	// Answer one cycle after the request; refused accesses fault
	always_ff @(posedge CLK) begin
		if (RST) begin
			MSR_ACK   <= 1'b0;
			MSR_FAULT <= 1'b0;
			MSR_RDATA <= 64'h0;
		end else begin
			MSR_ACK   <= MSR_RD || MSR_WR;
			MSR_FAULT <= (MSR_RD || MSR_WR) && !acc_ok;
			MSR_RDATA <= (MSR_RD && acc_ok) ? rd_val : 64'h0;
		end
	end

	// Effective hints; a per-processor register may defer to the package one
	logic        use_pkg;
	logic [63:0] req_sel;
	logic [7:0]  sel_max;
	assign use_pkg = HAS_PKG && proc_req_ff[REQ_PKG_BIT];
	assign req_sel = use_pkg ? pkg_req_ff : proc_req_ff;
	assign sel_max = req_sel[REQ_MAX_LSB +: 8];

	always_ff @(posedge CLK) begin
		if (RST) begin
			AUTO_SEL_EN      <= 1'b0;
			LEGACY_PERF_CTL  <= 64'h0;
			PERF_MIN_OUT     <= LOWEST_PERF;
			PERF_MAX_OUT     <= HIGHEST_PERF;
			PERF_DESIRED_OUT <= REQ_DES_RST;
			PERF_PREF_OUT    <= REQ_PREF_RST;
			PERF_WINDOW_OUT  <= '0;
			PERF_NOTIFY_IRQ  <= 1'b0;
		end else begin
			AUTO_SEL_EN      <= enable_ff;
			LEGACY_PERF_CTL  <= legacy_ff;
			PERF_MIN_OUT     <= req_sel[REQ_MIN_LSB +: 8];
			// Maximum below the efficient point buys no energy, so lift it
			PERF_MAX_OUT     <= (sel_max < effic_s) ? effic_s : sel_max;
			PERF_DESIRED_OUT <= req_sel[REQ_DES_LSB +: 8];
			PERF_PREF_OUT    <= HAS_PREF ? req_sel[REQ_PREF_LSB +: 8] : REQ_PREF_RST;
			PERF_WINDOW_OUT  <= req_sel[REQ_WIN_LSB +: REQ_WIN_W];
			PERF_NOTIFY_IRQ  <= HAS_NOTIFY &&
				((status_ff[ST_GUAR_BIT] && int_ctl_ff[IC_GUAR_BIT]) ||
				 (status_ff[ST_EXCUR_BIT] && int_ctl_ff[IC_EXCUR_BIT]));
		end
	end

endmodule

// *** src/phs_settle.sv ***
// Purpose: Commits a new level only after it has held unchanged long enough.
// Assumes: Input is already synchronised to clk.
// Notes:   First value after reset is taken without a change pulse.
module phs_settle
	import phs_pkg::*;
#(
	parameter int          W      = 8,
	parameter int unsigned CYCLES = 32'(SETTLE_CYC)
) (
	input  wire logic         clk,      // System clock
	input  wire logic         rst,      // Synchronous reset, high
	input  wire logic [W-1:0] level_in, // Raw level
	output logic      [W-1:0] level,    // Committed level
	output logic              changed   // Pulse on commit of a new level
);

	logic [W-1:0] cand_ff;
	logic [31:0]  cnt_ff;
	logic         primed_ff;

	initial begin
		if (CYCLES < 1) $error("phs_settle: CYCLES must be at least 1");
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			level     <= '0;
			cand_ff   <= '0;
			cnt_ff    <= 32'h0;
			primed_ff <= 1'b0;
			changed   <= 1'b0;
		end else begin
			changed   <= 1'b0;
			primed_ff <= 1'b1;
			cand_ff   <= level_in;
			if (!primed_ff) begin
				level  <= level_in;
				cnt_ff <= 32'h0;
			end else if (level_in == level || level_in != cand_ff) begin
				// Any wobble restarts the hold time
				cnt_ff <= 32'h0;
			end else if (cnt_ff + 32'h1 >= CYCLES) begin
				level   <= level_in;
				changed <= 1'b1;
				cnt_ff  <= 32'h0;
			end else begin
				cnt_ff <= cnt_ff + 32'h1;
			end
		end
	end

endmodule

// *** src/phs_sync.sv ***
// Purpose: Two-flop synchroniser for a bundle of level inputs.
// Assumes: Each bit is a slow level; the guaranteed level bundle is filtered downstream.
// Notes:   First stage is read only by the second stage.
module phs_sync
	import phs_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         clk,   // System clock
	input  wire logic         rst,   // Synchronous reset, high
	input  wire logic [W-1:0] d,     // Asynchronous levels
	output logic      [W-1:0] q      // Synchronised levels
);

	logic [W-1:0] meta_ff;

	initial begin
		if (W < 1) $error("phs_sync: W must be at least 1");
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_ff <= '0;
			q       <= '0;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end

endmodule

// *** tb/phs_regs_assertions.sv ***
// Purpose: Port-level checks on the performance hint register bank.
// Assumes: Default feature parameters, every feature present.
// Notes:   The enable output lags the stored enable bit by one cycle.
module phs_regs_chk
	import phs_pkg::*;
(
	input wire logic        CLK,             // System clock
	input wire logic        RST,             // Synchronous reset, high
	input wire logic        MSR_RD,          // Read request
	input wire logic        MSR_WR,          // Write request
	input wire logic [11:0] MSR_ADDR,        // Register index
	input wire logic [63:0] MSR_WDATA,       // Write data
	input wire logic [63:0] MSR_RDATA,       // Read data
	input wire logic        MSR_ACK,         // Answer
	input wire logic        MSR_FAULT,       // Refusal
	input wire logic [31:0] FEATURE_FLAGS,   // Identification word
	input wire logic        AUTO_SEL_EN,     // Autonomous selection on
	input wire logic [63:0] LEGACY_PERF_CTL, // Legacy control copy
	input wire logic        PERF_NOTIFY_IRQ  // Notification interrupt
);
	timeunit 1ns;
	timeprecision 100ps;

	logic en_wr1;
	logic cap_rd;

	// Plain nets, so $past sees a signal and not an expression
	assign en_wr1 = MSR_WR && MSR_ADDR == OFS_ENABLE && MSR_WDATA[EN_BIT];
	assign cap_rd = MSR_RD && MSR_ADDR == OFS_CAPABILITY;

	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	AST_ACK_NEXT: assert property ((MSR_RD || MSR_WR) |=> MSR_ACK)
		else $error("request not answered in one cycle");
	AST_EN_SET: assert property (en_wr1 |=> ##1 AUTO_SEL_EN)
		else $error("enable write did not switch mode on");
	AST_EN_CAUSE: assert property ($rose(AUTO_SEL_EN) |-> $past(en_wr1, 2))
		else $error("mode switched on without a write of one");
	AST_EN_STICKY: assert property (AUTO_SEL_EN |=> AUTO_SEL_EN)
		else $error("enable cleared without reset");
	AST_LEGACY_HOLD: assert property (AUTO_SEL_EN |=> $stable(LEGACY_PERF_CTL))
		else $error("legacy control changed while enabled");
	AST_CAP_GATE: assert property (cap_rd |=> MSR_FAULT == !AUTO_SEL_EN)
		else $error("capability gating wrong");
	AST_INTCTL_OPEN: assert property (MSR_RD && MSR_ADDR == OFS_INT_CTL |=> !MSR_FAULT)
		else $error("interrupt control refused");
	AST_CAP_RSVD: assert property (cap_rd |=> MSR_RDATA[63:32] == 32'h0)
		else $error("capability upper half not zero");
	AST_FLAGS: assert property (!$past(RST) |-> FEATURE_FLAGS == 32'h00000F80)
		else $error("identification word wrong");

	cover property ($rose(AUTO_SEL_EN));
	cover property ($rose(PERF_NOTIFY_IRQ));
	cover property (MSR_ACK && MSR_FAULT);
endmodule

bind phs_regs phs_regs_chk u_chk (
	.CLK(CLK), .RST(RST), .MSR_RD(MSR_RD), .MSR_WR(MSR_WR), .MSR_ADDR(MSR_ADDR),
	.MSR_WDATA(MSR_WDATA), .MSR_RDATA(MSR_RDATA), .MSR_ACK(MSR_ACK), .MSR_FAULT(MSR_FAULT),
	.FEATURE_FLAGS(FEATURE_FLAGS), .AUTO_SEL_EN(AUTO_SEL_EN),
	.LEGACY_PERF_CTL(LEGACY_PERF_CTL), .PERF_NOTIFY_IRQ(PERF_NOTIFY_IRQ)
);

// *** tb/phs_regs_test.sv ***
// Purpose: Self-checking bench for the performance hint register bank.
// Assumes: Settle count cut to 8 cycles; all features present.
// Notes:   Bus tasks leave one idle cycle between requests.
module phs_regs_test
	import phs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int LIMIT = 2000;
	logic        clk;
	logic        rst   = 1'b1;
	logic        rd    = 1'b0;
	logic        wr    = 1'b0;
	logic        minx  = 1'b0;
	logic        curl  = 1'b0;
	logic        xdom  = 1'b0;
	logic [11:0] addr  = 12'h0;
	logic [63:0] wdata = 64'h0;
	logic [7:0]  guar  = 8'h40;
	logic [7:0]  effic = 8'h30;
	logic        ack, fault, en, irq;
	logic [63:0] rdata, leg;
	logic [31:0] flags;
	logic [7:0]  pmin, pmax, pdes, ppref;
	logic [9:0]  pwin;
	int          err_total = 0;
	int          n_checks  = 0;
	int          cyc       = 0;

	phs_regs #(.SETTLE_CYCLES(8)) dut (
		.CLK(clk), .RST(rst), .MSR_RD(rd), .MSR_WR(wr), .MSR_ADDR(addr),
		.MSR_WDATA(wdata), .MSR_RDATA(rdata), .MSR_ACK(ack), .MSR_FAULT(fault),
		.FEATURE_FLAGS(flags), .GUAR_PERF_IN(guar), .EFFIC_PERF_IN(effic),
		.MIN_EXCURSION_IN(minx), .CURRENT_LIMIT_IN(curl), .CROSS_DOMAIN_IN(xdom),
		.PRODUCTIVE_IN(1'b0), .AUTO_SEL_EN(en), .LEGACY_PERF_CTL(leg),
		.PERF_MIN_OUT(pmin), .PERF_MAX_OUT(pmax), .PERF_DESIRED_OUT(pdes),
		.PERF_PREF_OUT(ppref), .PERF_WINDOW_OUT(pwin), .PERF_NOTIFY_IRQ(irq)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// A hang would otherwise never reach the verdict
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			err_total++;
			end_of_test();
		end
	end

	task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic idle(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Answer is sampled just after the edge that raises it
	task automatic req(logic r, logic [11:0] a, logic [63:0] d, logic f);
		@(posedge clk);
		rd    <= r;
		wr    <= ~r;
		addr  <= a;
		wdata <= d;
		@(posedge clk);
		rd <= 1'b0;
		wr <= 1'b0;
		#1;
		chk("ack", {63'h0, ack}, 64'h1);
		chk($sformatf("fault %h", a), {63'h0, fault}, {63'h0, f});
	endtask

	task automatic wr_reg(logic [11:0] a, logic [63:0] d, logic f = 1'b0);
		req(1'b0, a, d, f);
	endtask

	task automatic rd_reg(logic [11:0] a, logic [63:0] e, logic f = 1'b0);
		req(1'b1, a, 64'h0, f);
		chk($sformatf("data %h", a), rdata, e);
	endtask

	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		idle(2);
		chk("flags", {32'h0, flags}, 64'h0000000000000F80);
		chk("enable out", {63'h0, en}, 64'h0);
		rd_reg(OFS_ENABLE, 64'h0);
		rd_reg(OFS_CAPABILITY, 64'h0, 1'b1);
		rd_reg(OFS_STATUS, 64'h0, 1'b1);
		rd_reg(OFS_PROD_COUNT, 64'h0);
		wr_reg(OFS_INT_CTL, 64'h3);
		rd_reg(OFS_INT_CTL, 64'h3);
		rd_reg(12'h123, 64'h0, 1'b1);
		$display("test gating finished");

		wr_reg(OFS_LEGACY_CTL, 64'h0000000100000A5A);
		wr_reg(OFS_ENABLE, 64'h0);
		idle(2);
		chk("legacy", leg, 64'h0000000100000A5A);
		chk("enable out", {63'h0, en}, 64'h0);
		wr_reg(OFS_ENABLE, 64'h1);
		idle(1);
		chk("enable out", {63'h0, en}, 64'h1);
		wr_reg(OFS_ENABLE, 64'h0);
		rd_reg(OFS_ENABLE, 64'h1);
		wr_reg(OFS_LEGACY_CTL, 64'h0000000000001234);
		rd_reg(OFS_LEGACY_CTL, 64'h0000000100000A5A);
		chk("legacy", leg, 64'h0000000100000A5A);
		$display("test enable finished");

		rd_reg(OFS_CAPABILITY, 64'h00000000013040FF);
		wr_reg(OFS_PROC_REQ, 64'h00010003A0552010);
		rd_reg(OFS_PROC_REQ, 64'h00000003A0552010);
		idle(1);
		chk("max hint", {56'h0, pmax}, 64'h30);
		chk("min hint", {56'h0, pmin}, 64'h10);
		chk("desired hint", {56'h0, pdes}, 64'h55);
		chk("pref hint", {56'h0, ppref}, 64'hA0);
		chk("window hint", {54'h0, pwin}, 64'h3);
		wr_reg(OFS_PKG_REQ, 64'h0000000000004035);
		wr_reg(OFS_PROC_REQ, 64'h0000040000000000);
		idle(1);
		chk("pkg min hint", {56'h0, pmin}, 64'h35);
		chk("pkg max hint", {56'h0, pmax}, 64'h40);
		$display("test capability finished");

		// Short glitch must not commit, a held level must
		@(posedge clk);
		guar <= 8'h50;
		repeat (4) @(posedge clk);
		guar <= 8'h40;
		idle(20);
		rd_reg(OFS_STATUS, 64'h0);
		@(posedge clk);
		guar <= 8'h50;
		idle(20);
		rd_reg(OFS_STATUS, 64'h1);
		chk("irq", {63'h0, irq}, 64'h1);
		rd_reg(OFS_CAPABILITY, 64'h00000000013050FF);
		wr_reg(OFS_STATUS, 64'h0);
		idle(1);
		rd_reg(OFS_STATUS, 64'h0);
		chk("irq", {63'h0, irq}, 64'h0);
		@(posedge clk);
		minx <= 1'b1;
		curl <= 1'b1;
		xdom <= 1'b1;
		idle(6);
		rd_reg(OFS_STATUS, 64'h4);
		rd_reg(OFS_THERM, 64'hF000);
		chk("irq", {63'h0, irq}, 64'h1);
		wr_reg(OFS_STATUS, 64'h0);
		rd_reg(OFS_STATUS, 64'h0);
		wr_reg(OFS_THERM, 64'h0);
		rd_reg(OFS_THERM, 64'hF000);
		@(posedge clk);
		curl <= 1'b0;
		xdom <= 1'b0;
		idle(4);
		rd_reg(OFS_THERM, 64'hA000);
		wr_reg(OFS_THERM, 64'h0);
		rd_reg(OFS_THERM, 64'h0);
		$display("test notify finished");

		@(posedge clk);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		idle(2);
		chk("enable out", {63'h0, en}, 64'h0);
		rd_reg(OFS_ENABLE, 64'h0);
		$display("test reset finished");
		end_of_test();
	end
endmodule
